// [core/mpks_sequencer.sv]
`timescale 1ns/1ns
`default_nettype none

module mpks_sequencer
	import mpks_pkg::*;
#(
	parameter int unsigned ON_CYC   = ON_PRESS_CYC,
	parameter int unsigned OFF_CYC  = OFF_PRESS_CYC,
	parameter int unsigned RMIN_CYC = RST_MIN_CYC,
	parameter int unsigned RMAX_CYC = RST_MAX_CYC
)
(
	// clock, reset, enable
	input  wire logic          clk,
	input  wire logic          srst,
	input  wire logic          ce,
	// host pins
	input  wire logic          power_key_n,
	input  wire logic          reset_n,
	// software commands from the module's own command parser
	input  wire logic          software_power_off_command,
	input  wire logic          card_detect_config_command,
	input  wire mpks_pkg::mpks_cd_cfg_t card_detect_config,
	// card slot
	input  wire logic          card_detect_input,
	// open-drain status pin: low level driven while running
	output logic               status_o,
	output logic               status_oe,
	// module state
	output logic               module_on,
	output logic               module_reset_pulse,
	output logic               card_present,
	output logic               card_detect_enabled
);
	import mpks_pkg::*;

	mpks_state_t        state_r;
	mpks_state_t        state_nxt;
	logic [CNT_W-1:0]   key_cnt_r;
	logic [CNT_W-1:0]   rst_cnt_r;
	logic [CNT_W-1:0]   sd_cnt_r;
	logic               sw_off_r;
	logic               rst_pulse_r;
	logic               on_r;
	logic               present_r;
	mpks_cd_cfg_t       cd_cfg_r;

	// saturating increment, shared by both low-time counters and the shutdown timer
	function automatic logic [CNT_W-1:0] sat_inc(input logic [CNT_W-1:0] v);
		sat_inc = (v == {CNT_W{1'b1}}) ? v : v + 1'b1;
	endfunction : sat_inc

	// decoded events
	wire key_low     = ~power_key_n;
	wire on_valid    = (key_cnt_r >= (ON_CYC - 1));
	wire off_valid   = (key_cnt_r >= (OFF_CYC - 1));
	// a pulse is measured at its rising edge, so stray lengths do nothing
	wire rst_rise    = reset_n & (rst_cnt_r != '0);
	wire rst_valid   = rst_rise & (rst_cnt_r >= RMIN_CYC) & (rst_cnt_r <= RMAX_CYC);
	wire sd_done     = (sd_cnt_r == SHUTDOWN_CYC[CNT_W-1:0] - 1'b1);

	// state decodes shared by the next-state logic and the registers
	wire in_off      = (state_r == MPKS_OFF);
	wire in_on       = (state_r == MPKS_ON);
	wire in_wait_rel = (state_r == MPKS_WAIT_REL);
	wire in_shutdown = (state_r == MPKS_SHUTDOWN);
	wire in_reset    = (state_r == MPKS_RESET);
	// the off press holds the module up until release, so both count as running
	wire running     = in_on | in_wait_rel;

	// a software shutdown ending with the key still low comes straight back up;
	// an accepted reset pulse keeps priority so a stuck key cannot mask it
	wire sw_restart  = in_shutdown & sd_done & sw_off_r & key_low & ~rst_valid;

	// counter next values; the key count also restarts on any state change,
	// so one long tied-low press is not reused for on and then off
	wire [CNT_W-1:0] key_cnt_nxt = (!key_low || state_nxt != state_r) ?
		'0 : sat_inc(key_cnt_r);
	wire [CNT_W-1:0] rst_cnt_nxt = reset_n ? '0 : sat_inc(rst_cnt_r);
	// shutdown count stays far below saturation, the shared increment is safe
	wire [CNT_W-1:0] sd_cnt_nxt  = in_shutdown ? sat_inc(sd_cnt_r) : '0;

	// power state machine
	always_comb
	begin
		state_nxt = state_r;
		case (state_r)
			MPKS_OFF:
				if (key_low && on_valid)
					state_nxt = MPKS_ON;
			MPKS_ON:
				if (software_power_off_command)
					state_nxt = MPKS_SHUTDOWN;
				else if (key_low && off_valid)
					state_nxt = MPKS_WAIT_REL;
			MPKS_WAIT_REL:
				if (!key_low)
					state_nxt = MPKS_SHUTDOWN;
			MPKS_SHUTDOWN:
				if (sd_done)
					state_nxt = MPKS_OFF;
			MPKS_RESET:
				state_nxt = MPKS_ON;
			default:
				state_nxt = MPKS_OFF;
		endcase
		// reset pulse wins over everything while powered
		if (rst_valid && (state_r != MPKS_OFF))
			state_nxt = MPKS_RESET;
	end

	// key low-time counter; restarts on release and on each state change so
	// a single long press is not reused for on and then off (tied-low case)
	always_ff @(posedge clk)
	begin
		if (srst)
			key_cnt_r <= '0;
		else if (ce)
			key_cnt_r <= key_cnt_nxt;
	end

	// reset-line low-time counter, cleared one cycle after the rising edge
	always_ff @(posedge clk)
	begin
		if (srst)
			rst_cnt_r <= '0;
		else if (ce)
			rst_cnt_r <= rst_cnt_nxt;
	end

	// shutdown timer and software-origin flag
	always_ff @(posedge clk)
	begin
		if (srst)
		begin
			sd_cnt_r <= '0;
			sw_off_r <= 1'b0;
		end
		else if (ce)
		begin
			sd_cnt_r <= sd_cnt_nxt;
			if (in_on && software_power_off_command)
				sw_off_r <= 1'b1;
			else if (in_off)
				sw_off_r <= 1'b0;
		end
	end

	// state register; a key still low as a software shutdown ends restarts at once
	always_ff @(posedge clk)
	begin
		if (srst)
			state_r <= MPKS_OFF;
		else if (ce)
		begin
			if (sw_restart)
				state_r <= MPKS_ON;
			else
				state_r <= state_nxt;
		end
	end

	// registered outputs
	always_ff @(posedge clk)
	begin
		if (srst)
		begin
			on_r        <= 1'b0;
			rst_pulse_r <= 1'b0;
		end
		else if (ce)
		begin
			on_r        <= running;
			rst_pulse_r <= in_reset;
		end
	end

	// card detect configuration, honoured in every state except MPKS_OFF, which restores the reset value
	always_ff @(posedge clk)
	begin
		if (srst)
		begin
			cd_cfg_r  <= '{enable: CD_EN_RST, active_high: CD_ACT_HIGH_RST};
			present_r <= 1'b0;
		end
		else if (ce)
		begin
			if (in_off)
				cd_cfg_r <= '{enable: CD_EN_RST, active_high: CD_ACT_HIGH_RST};
			else if (card_detect_config_command)
				cd_cfg_r <= card_detect_config;
			present_r <= cd_cfg_r.enable &
				(cd_cfg_r.active_high ? card_detect_input : ~card_detect_input);
		end
	end

	// status pin: drive low while on, otherwise released to the pull-up
	assign status_o            = 1'b0;
	assign status_oe           = on_r;
	assign module_on           = on_r;
	assign module_reset_pulse  = rst_pulse_r;
	assign card_present        = present_r;
	assign card_detect_enabled = cd_cfg_r.enable;

endmodule : mpks_sequencer

`default_nettype wire

// [core/mpks_pkg.sv]
package mpks_pkg;

	// timing figures in their own units
	localparam int unsigned CLK_MHZ          = 100;
	localparam int unsigned ON_PRESS_MS      = 500;
	localparam int unsigned OFF_PRESS_MS     = 650;
	localparam int unsigned RST_MIN_MS       = 150;
	localparam int unsigned RST_MAX_MS       = 460;
	localparam int unsigned CYC_PER_MS       = CLK_MHZ * 1000;
	// least times round up, which at whole ms is exact
	localparam int unsigned ON_PRESS_CYC     = ON_PRESS_MS * CYC_PER_MS;
	localparam int unsigned OFF_PRESS_CYC    = OFF_PRESS_MS * CYC_PER_MS;
	localparam int unsigned RST_MIN_CYC      = RST_MIN_MS * CYC_PER_MS;
	localparam int unsigned RST_MAX_CYC      = RST_MAX_MS * CYC_PER_MS;
	// fixed length of the internal shutdown phase, in cycles
	localparam int unsigned SHUTDOWN_CYC     = 16;
	localparam int unsigned CNT_W            = 32;

	// card detect configuration reset value: detection off
	localparam logic        CD_EN_RST        = 1'b0;
	localparam logic        CD_ACT_HIGH_RST  = 1'b0;

	typedef enum logic [2:0]
	{
		MPKS_OFF      = 3'b000,
		MPKS_ON       = 3'b001,
		MPKS_WAIT_REL = 3'b010,
		MPKS_SHUTDOWN = 3'b011,
		MPKS_RESET    = 3'b100
	} mpks_state_t;

	// card detect configuration carried as one word
	typedef struct packed
	{
		logic enable;
		logic active_high;
	} mpks_cd_cfg_t;

endpackage : mpks_pkg

// [verification/mpks_sequencer_chk.sv]
`timescale 1ns/1ns
`default_nettype none
module mpks_chk
	import mpks_pkg::*;
(
	// clock, reset, enable
	input  wire logic                   clk,
	input  wire logic                   srst,
	input  wire logic                   ce,
	// host pins
	input  wire logic                   power_key_n,
	input  wire logic                   reset_n,
	// commands and card slot
	input  wire logic                   software_power_off_command,
	input  wire logic                   card_detect_config_command,
	input  wire mpks_pkg::mpks_cd_cfg_t card_detect_config,
	input  wire logic                   card_detect_input,
	// outputs of the sequencer
	input  wire logic                   status_o,
	input  wire logic                   status_oe,
	input  wire logic                   module_on,
	input  wire logic                   module_reset_pulse,
	input  wire logic                   card_present,
	input  wire logic                   card_detect_enabled
);
	default clocking @(posedge clk); endclocking
	default disable iff (srst);
	property p_oe; status_oe == module_on; endproperty
	a_oe: assert property (p_oe) else $error("status enable wrong");
	property p_od; !status_o; endproperty
	a_od: assert property (p_od) else $error("status data high");
	// a held key never stops the module by itself; pins are judged one cycle
	// ahead because module_on trails the state by a register
	property p_hold; ce && !power_key_n && !software_power_off_command && $stable(reset_n)
		##1 module_on |=> module_on; endproperty
	a_hold: assert property (p_hold) else $error("off while key held");
	property p_sw; module_on && power_key_n && software_power_off_command
		|-> ##[1:2] !module_on; endproperty
	a_sw: assert property (p_sw) else $error("soft off ignored");
	property p_rp; module_reset_pulse |-> !module_on ##1 (module_on && !module_reset_pulse);
	endproperty
	a_rp: assert property (p_rp) else $error("reset pulse shape");
	property p_cd; !card_detect_enabled [*2] |-> !card_present; endproperty
	a_cd: assert property (p_cd) else $error("card seen while off");
	property p_cdr; $fell(srst) |-> !card_detect_enabled && !module_on; endproperty
	a_cdr: assert property (p_cdr) else $error("bad reset state");
	// turning on needs a key press or a reset before it
	property p_on; $rose(module_on) |-> !$past(power_key_n, 2) || $past(module_reset_pulse);
	endproperty
	a_on: assert property (p_on) else $error("on without cause");
endmodule : mpks_chk
bind mpks_sequencer mpks_chk u_chk (.*);
`default_nettype wire

// [verification/mpks_host.sv]
`timescale 1ns/1ns
`default_nettype none
module mpks_host
(
	// clock and status seen by the host
	input  wire logic clk,
	input  wire logic status_oe,
	// open-drain host lines, released means high
	output logic      power_key_n,
	output logic      reset_n
);
	initial
	begin
		power_key_n = 1'b1;
		reset_n = 1'b1;
	end
	// timed key press, changed off the sampling edge
	task automatic key(input int n);
		power_key_n = 1'b0;
		repeat (n) @(negedge clk);
		power_key_n = 1'b1;
	endtask : key
	// press until the status pin is driven, then let go; bounded
	task automatic key_on(input int lim, output logic ok);
		int n;
		ok = 1'b0;
		power_key_n = 1'b0;
		for (n = 0; n < lim && !ok; n++)
		begin
			@(negedge clk);
			ok = (status_oe === 1'b1);
		end
		power_key_n = 1'b1;
	endtask : key_on
	task automatic lvl(input logic v);
		power_key_n = v;
	endtask : lvl
	task automatic rst(input int n);
		reset_n = 1'b0;
		repeat (n) @(negedge clk);
		reset_n = 1'b1;
	endtask : rst
endmodule : mpks_host
`default_nettype wire

// [verification/module_power_key_sequencer_tb.sv]
`timescale 1ns/1ns
`default_nettype none
module module_power_key_sequencer_tb;
	import mpks_pkg::*;
	logic         clk = 1'b0, srst = 1'b1, ce = 1'b1, swoff = 1'b0, cdcmd = 1'b0, cdin = 1'b0;
	int           lens[4] = '{2, 3, 8, 9};
	mpks_cd_cfg_t cdcfg = '0;
	logic         pk_n, rs_n, st_o, st_oe, mon, rpul, cpres, cden, hit;
	int           error_cnt = 0, check_count = 0, pulses = 0, k;
	always #5 clk = ~clk;
	// accepted resets are counted so refused ones show as no change
	always @(posedge clk) if (rpul === 1'b1) pulses++;
	mpks_host u_host (.clk(clk), .status_oe(st_oe), .power_key_n(pk_n), .reset_n(rs_n));
	mpks_sequencer #(.ON_CYC(4), .OFF_CYC(6), .RMIN_CYC(3), .RMAX_CYC(8)) uut (
		.clk(clk), .srst(srst), .ce(ce), .power_key_n(pk_n), .reset_n(rs_n),
		.software_power_off_command(swoff), .card_detect_config_command(cdcmd),
		.card_detect_config(cdcfg), .card_detect_input(cdin), .status_o(st_o),
		.status_oe(st_oe), .module_on(mon), .module_reset_pulse(rpul),
		.card_present(cpres), .card_detect_enabled(cden));
	task chk(input logic g, input logic e);
		check_count++;
		if (g !== e)
		begin
			error_cnt++;
			$display("unexpected at %0t: got %h want %h", $time, g, e);
		end
	endtask : chk
	task w(input int n);
		repeat (n) @(negedge clk);
	endtask : w
	task sw;
		swoff = 1'b1;
		w(1);
		swoff = 1'b0;
	endtask : sw
	task t_key;
		u_host.key(3);
		w(4);
		chk(mon, 1'b0);
		u_host.key(4);
		w(2);
		chk(mon, 1'b1);
		chk(st_oe, 1'b1);
		chk(st_o, 1'b0);
		u_host.key(5);
		w(20);
		chk(mon, 1'b1);
		u_host.key(12);
		chk(mon, 1'b1);
		w(2);
		chk(mon, 1'b0);
		chk(st_oe, 1'b0);
		$display("key test end");
	endtask : t_key
	task t_rst;
		// the key shutdown of the previous test must finish first
		w(20);
		u_host.key_on(10, hit);
		chk(hit, 1'b1);
		// lengths below, at, at and above the window
		foreach (lens[i])
		begin
			k = pulses;
			u_host.rst(lens[i]);
			w(4);
			chk(pulses != k, i == 1 || i == 2);
			chk(mon, 1'b1);
		end
		// a long press that the frozen sequencer never sees
		ce = 1'b0;
		u_host.key(8);
		ce = 1'b1;
		w(4);
		chk(mon, 1'b1);
		$display("reset test end");
	endtask : t_rst
	task t_sw;
		sw();
		w(2);
		chk(mon, 1'b0);
		w(20);
		k = pulses;
		u_host.rst(4);
		w(4);
		chk(mon, 1'b0);
		chk(pulses != k, 1'b0);
		u_host.key_on(10, hit);
		chk(hit, 1'b1);
		sw();
		u_host.lvl(1'b0);
		w(1);
		chk(mon, 1'b0);
		// key still low as the software shutdown ends: straight back on
		w(SHUTDOWN_CYC);
		chk(mon, 1'b1);
		u_host.lvl(1'b1);
		$display("soft off test end");
	endtask : t_sw
	task t_cd;
		chk(cden, 1'b0);
		for (k = 0; k < 5; k++)
		begin
			cdcfg = {k < 4, k[1]};
			cdin = k[0];
			cdcmd = 1'b1;
			w(1);
			cdcmd = 1'b0;
			w(3);
			chk(cpres, k < 4 && !(k[1] ^ k[0]));
			chk(cden, k < 4);
		end
		sw();
		w(20);
		chk(cden, 1'b0);
		u_host.lvl(1'b0);
		w(40);
		chk(mon, 1'b1);
		$display("card test end");
	endtask : t_cd
	task results;
		$display("checks %0d mismatches %0d", check_count, error_cnt);
		if (error_cnt == 0 && check_count > 0)
			$display("DONE - PASS");
		else
			$display("DONE - FAIL");
		$finish;
	endtask : results
	initial
	begin
		w(6);
		srst = 1'b0;
		w(4);
		t_key();
		t_rst();
		t_sw();
		t_cd();
		results();
	end
endmodule : module_power_key_sequencer_tb
`default_nettype wire
